// ---- verilog/nfc_host.v ----
/*
 * nand flash host controller: issues reset, id read, get/set feature,
 * read status and the 00h read on the multiplexed dq bus, under
 * command of software over a classic wishbone slave port.
 * assumes the flash pins arrive asynchronously (synchronised here) and
 * that dqs follows re_n edges during data output.
 */
// Functional notes
// R1: device keeps written feature until changed
// R2: feature 89h read retry, zero means off
// R3: retry bytes are signed step counts
// R4: host reads all four feature bytes first
// R5: after status polling, issue 00h first
// R6: get feature returns 02h, 10h, 30h settings
// R7: id read is 90h plus one address
// R8: host runs id reads below 66 mhz
// R9: address 00h gives six id bytes
// R10: device stays in id mode until command
// R11: third id byte encoding
// R12: fourth id byte encoding
// R13: fifth id byte encoding
// R14: sixth id byte encoding
// R15: address 40h gives six signature bytes
// R16: sixth signature byte marks interface type
// R17: status reports last operation, combined planes
// R18: status byte bit encoding
// R19: cache operations use dq5 and dq6
// R20: ffh aborts any operation
// R21: no power-on reset before ready
// R22: new reset restarts reset in progress
// R23: wait on ready/busy after feature access
`timescale 1ns/1ps
`include "nfc_defs.vh"

module nfc_host (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rst_n,
  // wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // flash control pins
  output reg         ce_n,
  output reg         cle,
  output reg         ale,
  output reg         we_n,
  output reg         re_n,
  input  wire        rb_n_i,
  // flash dq and dqs
  input  wire [7:0]  dq_i,
  output reg  [7:0]  dq_o,
  output reg         dq_oe,
  input  wire        dqs_i,
  output reg         dqs_o,
  output reg         dqs_oe
);

  // --------------------------------------------------------------------
  // states and timing
  // --------------------------------------------------------------------
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_PRE  = 3'h1;
  localparam [2:0] S_CMD  = 3'h2;
  localparam [2:0] S_ADR  = 3'h3;
  localparam [2:0] S_WR   = 3'h4;
  localparam [2:0] S_BUSY = 3'h5;
  localparam [2:0] S_GAP  = 3'h6;
  localparam [2:0] S_RD   = 3'h7;

  localparam [3:0] W_FALL = 4'h1;
  // two-clock strobe phases keep every we_n and dqs transfer far below 66 mhz
  localparam [3:0] W_RISE = `NFC_STROBE_CYC + 4'h1;  // R8
  localparam [3:0] W_END  = `NFC_STROBE_CYC + `NFC_STROBE_CYC + 4'h1;
  localparam [3:0] WB_CYC = `NFC_WB_CYC;
  localparam [3:0] WHR_CYC = `NFC_WHR_CYC;

  reg  [2:0]  state_r;
  reg  [3:0]  cnt_r;
  reg  [2:0]  idx_r;
  reg  [2:0]  op_r;
  reg  [7:0]  faddr_r;
  reg  [31:0] wparam_r;
  reg  [7:0]  rbuf_r [0:5];
  reg         done_r;
  reg         refused_r;
  reg         por_done_r;
  reg         rb_m_r, rb_s_r, dqs_m_r, dqs_s_r;
  reg  [7:0]  dq_m_r, dq_s_r;

  // --------------------------------------------------------------------
  // pin synchronisers: flash pins are asynchronous to clk_sys
  // --------------------------------------------------------------------
  always @(posedge clk_sys) begin
    rb_m_r  <= rb_n_i;
    rb_s_r  <= rb_m_r;
    dqs_m_r <= dqs_i;
    dqs_s_r <= dqs_m_r;
    dq_m_r  <= dq_i;
    dq_s_r  <= dq_m_r;
  end

  // --------------------------------------------------------------------
  // per-operation plan
  // --------------------------------------------------------------------
  reg [7:0] cmd_byte;
  reg [2:0] nrd;
  always @* begin
    case (op_r)
      `NFC_OP_RESET:    cmd_byte = `NFC_CMD_RESET;
      `NFC_OP_READ_ID:  cmd_byte = `NFC_CMD_READ_ID;
      `NFC_OP_GET_FEAT: cmd_byte = `NFC_CMD_GET_FEAT;
      `NFC_OP_SET_FEAT: cmd_byte = `NFC_CMD_SET_FEAT;
      `NFC_OP_STATUS:   cmd_byte = `NFC_CMD_STATUS;
      default:          cmd_byte = `NFC_CMD_READ;
    endcase
    // get feature and 00h read always fetch all four bytes
    if (op_r == `NFC_OP_READ_ID)
      nrd = `NFC_ID_BYTES;
    else if (op_r == `NFC_OP_STATUS)
      nrd = `NFC_STAT_BYTES;
    else
      nrd = `NFC_PARAM_BYTES;  // R4 R5
  end

  wire has_adr = (op_r == `NFC_OP_READ_ID) || (op_r == `NFC_OP_GET_FEAT) ||
                 (op_r == `NFC_OP_SET_FEAT);

  // --------------------------------------------------------------------
  // wishbone access decode
  // --------------------------------------------------------------------
  wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // writes land at the edge that samples ack high, while the master still holds
  wire wb_wr  = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i;
  wire start  = wb_wr && (wb_adr_i == `NFC_ADR_CTRL) && wb_sel_i[0];
  wire busy   = (state_r != S_IDLE);
  // a reset may be reissued at any time, all else is refused unless idle
  wire go     = start && (!busy || wb_dat_i[2:0] == `NFC_OP_RESET);  // R22
  wire st_clr = wb_wr && (wb_adr_i == `NFC_ADR_STATUS) && wb_sel_i[0];
  wire fin    = (state_r == S_RD) && (cnt_r != 4'h0) &&
                (dqs_s_r == re_n) && (idx_r == nrd - 3'h1);
  wire fin_nr = (state_r == S_BUSY) && (cnt_r >= WB_CYC) && rb_s_r &&
                (op_r != `NFC_OP_GET_FEAT);

  // slave answers one cycle after the request and drops ack next cycle
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        if (wb_adr_i == `NFC_ADR_CTRL)
          wb_dat_o <= {29'h0, op_r};
        else if (wb_adr_i == `NFC_ADR_FADDR)
          wb_dat_o <= {24'h0, faddr_r};
        else if (wb_adr_i == `NFC_ADR_WPARAM)
          wb_dat_o <= wparam_r;
        else if (wb_adr_i == `NFC_ADR_RDLO)
          wb_dat_o <= {rbuf_r[3], rbuf_r[2], rbuf_r[1], rbuf_r[0]};
        else if (wb_adr_i == `NFC_ADR_RDHI)
          wb_dat_o <= {16'h0, rbuf_r[5], rbuf_r[4]};
        else if (wb_adr_i == `NFC_ADR_STATUS)
          wb_dat_o <= {28'h0, refused_r, done_r, rb_s_r, busy};
        else
          wb_dat_o <= 32'h0000_0000;
      end
    end
  end

  // --------------------------------------------------------------------
  // software registers and sticky flags
  // --------------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      faddr_r    <= 8'h00;
      wparam_r   <= 32'h0000_0000;
      done_r     <= 1'b0;
      refused_r  <= 1'b0;
      por_done_r <= 1'b0;
    end else begin
      if (wb_wr && wb_adr_i == `NFC_ADR_FADDR && wb_sel_i[0])
        faddr_r <= wb_dat_i[7:0];
      if (wb_wr && wb_adr_i == `NFC_ADR_WPARAM) begin
        if (wb_sel_i[0]) wparam_r[7:0]   <= wb_dat_i[7:0];
        if (wb_sel_i[1]) wparam_r[15:8]  <= wb_dat_i[15:8];
        if (wb_sel_i[2]) wparam_r[23:16] <= wb_dat_i[23:16];
        if (wb_sel_i[3]) wparam_r[31:24] <= wb_dat_i[31:24];
      end
      // set beats clear so a finish in the clearing cycle is kept
      if (fin || fin_nr)
        done_r <= 1'b1;
      else if (st_clr && wb_dat_i[`NFC_ST_DONE])
        done_r <= 1'b0;
      if (start && !go)
        refused_r <= 1'b1;
      else if (st_clr && wb_dat_i[`NFC_ST_REFUSED])
        refused_r <= 1'b0;
      // first ready after power-up opens the way for reset
      if (rb_s_r)
        por_done_r <= 1'b1;  // R21
    end
  end

  // --------------------------------------------------------------------
  // bus sequencer
  // --------------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      state_r <= S_IDLE;
      cnt_r   <= 4'h0;
      idx_r   <= 3'h0;
      op_r    <= `NFC_OP_RESET;
      ce_n    <= 1'b1;
      cle     <= 1'b0;
      ale     <= 1'b0;
      we_n    <= 1'b1;
      re_n    <= 1'b1;
      dq_o    <= 8'h00;
      dq_oe   <= 1'b0;
      dqs_o   <= 1'b0;
      dqs_oe  <= 1'b0;
    end else if (go) begin
      // a restart abandons any half-done bus cycle cleanly
      op_r    <= wb_dat_i[2:0];
      state_r <= S_PRE;
      cnt_r   <= 4'h0;
      idx_r   <= 3'h0;
      ce_n    <= 1'b0;
      cle     <= 1'b0;
      ale     <= 1'b0;
      we_n    <= 1'b1;
      re_n    <= 1'b1;
      dq_oe   <= 1'b0;
      dqs_oe  <= 1'b0;
    end else begin
      case (state_r)
        S_IDLE: begin
          ce_n <= 1'b1;
        end
        S_PRE: begin
          // reset waits only for the first ready after power-up, other commands wait for the target to be ready
          if (op_r == `NFC_OP_RESET ? por_done_r : rb_s_r) begin  // R21
            state_r <= S_CMD;
            cnt_r   <= 4'h0;
          end
        end
        S_CMD, S_ADR, S_WR: begin
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == 4'h0) begin
            cle    <= (state_r == S_CMD);
            ale    <= (state_r == S_ADR);
            dq_oe  <= 1'b1;
            dqs_oe <= (state_r == S_WR);
            if (state_r == S_CMD)
              dq_o <= cmd_byte;  // R7 R20
            else if (state_r == S_ADR)
              dq_o <= faddr_r;   // R7
            else
              dq_o <= wparam_r[8 * idx_r +: 8];
          end
          // command and address latch on we_n, data on dqs edges
          if (cnt_r == W_FALL && state_r != S_WR)
            we_n <= 1'b0;
          if (cnt_r == W_RISE) begin
            if (state_r == S_WR)
              dqs_o <= ~dqs_o;
            else
              we_n <= 1'b1;
          end
          if (cnt_r == W_END) begin
            cnt_r <= 4'h0;
            cle   <= 1'b0;
            ale   <= 1'b0;
            if (state_r == S_CMD) begin
              dq_oe <= 1'b0;
              if (has_adr)
                state_r <= S_ADR;
              else if (op_r == `NFC_OP_RESET)
                state_r <= S_BUSY;
              else
                state_r <= S_GAP;
            end else if (state_r == S_ADR) begin
              if (op_r == `NFC_OP_SET_FEAT) begin
                state_r <= S_WR;
                dqs_o   <= 1'b0;
              end else begin
                dq_oe   <= 1'b0;
                state_r <= (op_r == `NFC_OP_GET_FEAT) ? S_BUSY : S_GAP;
              end
            end else begin
              idx_r <= idx_r + 3'h1;
              if (idx_r == `NFC_PARAM_BYTES - 3'h1) begin
                idx_r   <= 3'h0;
                dq_oe   <= 1'b0;
                dqs_oe  <= 1'b0;
                state_r <= S_BUSY;
              end
            end
          end
        end
        S_BUSY: begin
          // let ready/busy fall before trusting its return to ready
          if (cnt_r < WB_CYC)
            cnt_r <= cnt_r + 4'h1;
          else if (rb_s_r) begin  // R23
            cnt_r   <= 4'h0;
            state_r <= (op_r == `NFC_OP_GET_FEAT) ? S_GAP : S_IDLE;
            ce_n    <= (op_r != `NFC_OP_GET_FEAT);
          end
        end
        S_GAP: begin
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == WHR_CYC) begin
            cnt_r   <= 4'h0;
            state_r <= S_RD;
          end
        end
        default: begin
          // each re_n edge yields one byte, taken when dqs follows it
          if (cnt_r == 4'h0) begin
            re_n  <= ~re_n;
            cnt_r <= 4'h1;
          end else if (dqs_s_r == re_n) begin
            rbuf_r[idx_r] <= dq_s_r;
            cnt_r         <= 4'h0;
            idx_r         <= idx_r + 3'h1;
            if (fin) begin  // R4
              state_r <= S_IDLE;
              re_n    <= 1'b1;
              ce_n    <= 1'b1;
            end
          end
        end
      endcase
    end
  end

endmodule

// ---- verilog/nfc_defs.vh ----
/*
 * constants for the nand flash host controller: register map, op codes,
 * command bytes and pin timing.
 * assumes a 20 mhz system clock and a wishbone slave port with byte addresses.
 */
`ifndef NFC_DEFS_VH
`define NFC_DEFS_VH

// ----------------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------------
`define NFC_ADR_CTRL    8'h00
`define NFC_ADR_FADDR   8'h04
`define NFC_ADR_WPARAM  8'h08
`define NFC_ADR_RDLO    8'h0C
`define NFC_ADR_RDHI    8'h10
`define NFC_ADR_STATUS  8'h14

// status register bit positions
`define NFC_ST_BUSY     0
`define NFC_ST_READY    1
`define NFC_ST_DONE     2
`define NFC_ST_REFUSED  3

// ----------------------------------------------------------------------
// operation codes written to the control register
// ----------------------------------------------------------------------
`define NFC_OP_RESET    3'h0
`define NFC_OP_READ_ID  3'h1
`define NFC_OP_GET_FEAT 3'h2
`define NFC_OP_SET_FEAT 3'h3
`define NFC_OP_STATUS   3'h4
`define NFC_OP_READ     3'h5

// ----------------------------------------------------------------------
// command bytes placed on dq
// ----------------------------------------------------------------------
`define NFC_CMD_RESET    8'hFF
`define NFC_CMD_READ_ID  8'h90
`define NFC_CMD_GET_FEAT 8'hEE
`define NFC_CMD_SET_FEAT 8'hEF
`define NFC_CMD_STATUS   8'h70
`define NFC_CMD_READ     8'h00

// byte counts of each phase
`define NFC_ID_BYTES     3'h6
`define NFC_PARAM_BYTES  3'h4
`define NFC_STAT_BYTES   3'h1

// ----------------------------------------------------------------------
// timing: figures in ns, cycle counts derived from the clock period
// ----------------------------------------------------------------------
`define NFC_CLK_NS      50
`define NFC_T_STROBE_NS 100
`define NFC_T_WB_NS     200
`define NFC_T_WHR_NS    120
// cycle counts: each ns figure above rounded up to whole clocks, sized
// to the 4-bit phase counter so no compare or load is silently cut
`define NFC_STROBE_CYC  4'h2
`define NFC_WB_CYC      4'h4
`define NFC_WHR_CYC     4'h3

`endif

// ---- verification/nfc_host_chk.sv ----
/* pin and bus assertions for the nand host controller.
   assumes binding onto nfc_host with one clock domain. */
`timescale 1ns/1ps
`include "nfc_defs.vh"
module nfc_host_chk (
  // clock and reset
  input logic       clk_sys,
  input logic       rst_n,
  // wishbone
  input logic       wb_cyc_i,
  input logic       wb_stb_i,
  input logic       wb_ack_o,
  // flash pins
  input logic       ce_n,
  input logic       cle,
  input logic       ale,
  input logic       we_n,
  input logic       re_n,
  input logic       rb_n_i,
  input logic [7:0] dq_o,
  input logic       dq_oe
);
  // ----------------------------------------------------------------
  // helpers: ready seen since reset, read strobes since last command
  // ----------------------------------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic       rdy_seen_r;
  logic       gf_r;
  logic       re_q_r;
  logic [3:0] nrd_r;
  // count saturates so a long id read cannot wrap back into range
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      rdy_seen_r <= 1'b0;
      gf_r       <= 1'b0;
      re_q_r     <= 1'b1;
      nrd_r      <= 4'h0;
    end else begin
      re_q_r <= re_n;
      if (rb_n_i)
        rdy_seen_r <= 1'b1;
      if (cle && dq_oe) begin
        gf_r  <= (dq_o == `NFC_CMD_GET_FEAT) || (dq_o == `NFC_CMD_READ);
        nrd_r <= 4'h0;
      end else if (re_n != re_q_r && nrd_r != 4'hF)
        nrd_r <= nrd_r + 4'h1;
    end
  end
  property p_ack_lat; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("late ack");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack unasked");
  property p_we_pair; !we_n |-> (cle ^ ale) && dq_oe && !ce_n; endproperty
  a_we_pair: assert property (p_we_pair) else $error("bad latch");
  property p_cmd_cycle;
    $rose(cle) |-> we_n ##1 (!we_n && cle)[*2] ##1 (we_n && cle)[*2];
  endproperty
  a_cmd_cycle: assert property (p_cmd_cycle) else $error("cmd shape");
  property p_ce_idle; ce_n |-> we_n && re_n && !cle && !ale && !dq_oe;
  endproperty
  a_ce_idle: assert property (p_ce_idle) else $error("pins active");
  property p_por_wait; $rose(cle) && dq_o == `NFC_CMD_RESET |-> rdy_seen_r;
  endproperty
  a_por_wait: assert property (p_por_wait) else $error("early reset");
  property p_feat_all;
    $rose(cle) && dq_o != `NFC_CMD_RESET && gf_r && nrd_r != 4'h0
      |-> nrd_r >= 4'h4;
  endproperty
  a_feat_all: assert property (p_feat_all) else $error("short read");
  property p_re_rate; $changed(re_n) |=> $stable(re_n); endproperty
  a_re_rate: assert property (p_re_rate) else $error("re too fast");
  property p_rd_quiet; !re_n |-> !dq_oe; endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("dq contention");
  c_reset: cover property ($rose(cle) && dq_o == `NFC_CMD_RESET);
  c_getf: cover property ($rose(cle) && dq_o == `NFC_CMD_GET_FEAT);
  c_id: cover property ($rose(cle) && dq_o == `NFC_CMD_READ_ID);
endmodule
bind nfc_host nfc_host_chk u_nfc_host_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .ce_n(ce_n), .cle(cle),
  .ale(ale), .we_n(we_n), .re_n(re_n), .rb_n_i(rb_n_i), .dq_o(dq_o),
  .dq_oe(dq_oe)
);

// ---- verification/nfc_flash_model.sv ----
/* behavioural flash target: commands, id, features, status, reset.
   assumes dq arrives already resolved from both drivers, dqs as the host's raw dqs_o and dqs_oe. */
`timescale 1ns/1ps
module nfc_flash_model #(
  parameter [7:0]  MAKER  = 8'h5A,
  parameter [7:0]  DEVICE = 8'h3C,
  parameter [39:0] SIG    = 40'h5453525150
) (
  // host side
  input  logic       ce_n,
  input  logic       cle,
  input  logic       ale,
  input  logic       we_n,
  input  logic       re_n,
  input  logic [7:0] dq_w,
  input  logic       dqs_o,
  input  logic       dqs_oe,
  input  logic       slow,
  // target side
  output logic [7:0] dq,
  output logic       dqs,
  output logic       rb_n
);
  logic [31:0] feat [0:255];
  logic [47:0] obuf;
  logic [31:0] fbuf;
  logic [31:0] wp;
  logic [7:0]  cmd;
  logic [7:0]  addr;
  logic [7:0]  dq_r;
  logic [3:0]  idx;
  logic [2:0]  wc;
  time         busy_end;
  integer      i;
  // power-up busy window keeps the first reset waiting
  initial begin
    for (i = 0; i < 256; i++)
      feat[i] = 32'h0;
    busy_end = 2000;
    rb_n = 1'b0;
    dqs = 1'b1;
    dq_r = 8'h00;
    idx = 4'h0;
    wc = 3'h4;
    cmd = 8'h00;
  end
  // a new reset only moves the deadline, so it restarts cleanly
  always #10 rb_n = ($time >= busy_end);
  // released bus shows the inverse so stale data never looks valid
  assign dq = ce_n ? ~dq_r : dq_r;
  // a deselected target lets its strobe return to the idle high level,
  // so a stale low from an odd-length read never looks like an echo
  always @(posedge ce_n) dqs = 1'b1;
  // command and address latch on the rising write strobe
  always @(posedge we_n) begin
    if (!ce_n && cle) begin
      cmd = dq_w;
      idx = 4'h0;
      if (cmd == 8'hFF)
        busy_end = $time + 500;
      if (cmd == 8'h70)
        obuf = {40'h0, 1'b1, rb_n, rb_n, 5'h00};
      if (cmd == 8'h00)
        obuf = {16'h0, fbuf};
    end else if (!ce_n && ale) begin
      addr = dq_w;
      wc = 3'h0;
      if (cmd == 8'h90)
        obuf = (addr == 8'h00) ? {1'b1, 1'b1, 2'b00, 4'h5,
          4'hA, 3'b000, 1'b0, 1'b1, 1'b1, 4'b0000, 2'b11,
          1'b1, 1'b0, 2'b00, 2'b00, 2'b01, DEVICE, MAKER}
          : {8'h02, SIG};
      if (cmd == 8'hEE) begin
        fbuf = feat[addr];
        obuf = {16'h0, fbuf};
        busy_end = $time + (slow ? 1500 : 300);
      end
    end
  end
  // parameter bytes arrive on strobe edges; retry bytes kept as signed
  always @(dqs_o) begin
    if (dqs_oe && !ce_n && !cle && !ale && cmd == 8'hEF && wc < 3'h4) begin
      wp[8*wc +: 8] = dq_w;
      wc = wc + 3'h1;
      if (wc == 3'h4) begin
        feat[addr] = wp;
        busy_end = $time + (slow ? 1500 : 300);
      end
    end
  end
  // every read strobe edge with ce_n low hands out a byte and echoes it on dqs
  always @(re_n) begin
    if (!ce_n) begin
      #(slow ? 130 : 5);
      dq_r = (idx < 4'h6) ? obuf[8*idx +: 8] : 8'h00;
      dqs = re_n;
      idx = idx + 4'h1;
    end
  end
endmodule

// ---- verification/nfc_host_bench.sv ----
/* self-checking bench for the nand host controller.
   assumes the behavioural flash model on the far side. */
`timescale 1ns/1ps
`include "nfc_defs.vh"
module nfc_host_bench;
  localparam [7:0]  MAKER  = 8'h5A; // arbitrary value
  localparam [7:0]  DEVICE = 8'h3C; // arbitrary value
  localparam [39:0] SIG    = 40'h5453525150; // arbitrary value
  logic        clk_sys, rst_n, cyc, stb, we, slow;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, seed, p;
  logic [47:0] e;
  logic [31:0] exp_f [0:3];
  logic [7:0]  fas [0:3] = '{8'h02, 8'h10, 8'h30, 8'h89};
  wire  [31:0] dat_o;
  wire  [7:0]  dq_o, dq_m;
  wire         ack, ce_n, cle, ale, we_n, re_n, rb_n;
  wire         dq_oe, dqs_o, dqs_oe, dqs_m;
  wire  [7:0]  dq_w = dq_oe ? dq_o : dq_m;
  wire         dqs_w = dqs_oe ? dqs_o : dqs_m;
  integer      err_total, n_tests, cyc_cnt, k;
  nfc_host u_nfc_host (.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .ce_n(ce_n),
    .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n), .rb_n_i(rb_n),
    .dq_i(dq_w), .dq_o(dq_o), .dq_oe(dq_oe), .dqs_i(dqs_w), .dqs_o(dqs_o),
    .dqs_oe(dqs_oe));
  nfc_flash_model #(.MAKER(MAKER), .DEVICE(DEVICE), .SIG(SIG))
    u_nfc_flash_model (.ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
    .re_n(re_n), .dq_w(dq_w), .dqs_o(dqs_o), .dqs_oe(dqs_oe), .slow(slow),
    .dq(dq_m), .dqs(dqs_m), .rb_n(rb_n));
  // ----------------------------------------------------------------
  // clock, helpers and bus tasks
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // id bytes built field by field, first byte in the low bits
  function [47:0] exp_id(input [7:0] a);
    exp_id = (a == 8'h00) ? {1'b1, 1'b1, 2'b00, 4'h5, 4'hA, 3'b000, 1'b0,
      1'b1, 1'b1, 4'b0000, 2'b11, 1'b1, 1'b0, 2'b00, 2'b00, 2'b01, DEVICE,
      MAKER} : {8'h02, SIG};
  endfunction
  task conclude;
    if (err_total == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input [31:0] g, input [31:0] x);
    n_tests = n_tests + 1;
    if (g !== x) begin
      err_total = err_total + 1;
      $display("ERROR %0t got %h expected %h", $time, g, x);
    end
  endtask
  // request held until the edge that samples ack high
  task wb(input w, input [7:0] a, input [31:0] d);
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk_sys);
    while (ack !== 1'b1)
      @(posedge clk_sys);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task wait_done;
    rdat = 32'h0;
    while (rdat[`NFC_ST_DONE] !== 1'b1)
      wb(1'b0, `NFC_ADR_STATUS, 32'h0);
    // a finished operation leaves the sequencer idle and the target ready
    chk({30'h0, rdat[`NFC_ST_READY], rdat[`NFC_ST_BUSY]}, 32'h2);
    wb(1'b1, `NFC_ADR_STATUS, 32'hC);
  endtask
  task op(input [2:0] o, input [7:0] fa, input [31:0] d);
    wb(1'b1, `NFC_ADR_FADDR, {24'h0, fa});
    wb(1'b1, `NFC_ADR_WPARAM, d);
    wb(1'b1, `NFC_ADR_CTRL, {29'h0, o});
    wait_done;
  endtask
  // hang guard: a limit reached is counted as a mismatch
  always @(posedge clk_sys) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 40000) begin
      err_total = err_total + 1;
      conclude;
    end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_n, cyc, stb, we, slow, adr, wdat} = '0;
    {err_total, n_tests, cyc_cnt} = '0;
    seed = 32'hB55E83FB;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    op(`NFC_OP_RESET, 8'h00, 32'h0);
    wb(1'b0, 8'h40, 32'h0);
    chk(rdat, 32'h0);
    op(`NFC_OP_GET_FEAT, 8'h89, 32'h0);
    wb(1'b0, `NFC_ADR_RDLO, 32'h0);
    chk(rdat, 32'h0);
    for (k = 0; k < 2; k++) begin
      e = exp_id(k ? 8'h40 : 8'h00);
      op(`NFC_OP_READ_ID, k ? 8'h40 : 8'h00, 32'h0);
      wb(1'b0, `NFC_ADR_RDLO, 32'h0);
      chk(rdat, e[31:0]);
      wb(1'b0, `NFC_ADR_RDHI, 32'h0);
      chk(rdat, {16'h0, e[47:32]});
    end
    op(`NFC_OP_STATUS, 8'h00, 32'h0);
    wb(1'b0, `NFC_ADR_RDLO, 32'h0);
    chk({24'h0, rdat[7:0]}, {24'h0, 1'b1, 1'b1, 1'b1, 5'h00});
    for (k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      p = (k == 3) ? 32'h0 : (k == 7) ? 32'h04FC01FF : seed;
      exp_f[k % 4] = p;
      slow <= k[0];
      op(`NFC_OP_SET_FEAT, fas[k % 4], p);
      op(`NFC_OP_GET_FEAT, fas[k % 4], 32'h0);
      wb(1'b0, `NFC_ADR_RDLO, 32'h0);
      chk(rdat, p);
    end
    op(`NFC_OP_STATUS, 8'h00, 32'h0);
    op(`NFC_OP_READ, 8'h00, 32'h0);
    wb(1'b0, `NFC_ADR_RDLO, 32'h0);
    chk(rdat, exp_f[3]);
    wb(1'b1, `NFC_ADR_FADDR, 32'h10);
    wb(1'b1, `NFC_ADR_CTRL, {29'h0, `NFC_OP_GET_FEAT});
    wb(1'b1, `NFC_ADR_CTRL, {29'h0, `NFC_OP_STATUS});
    wb(1'b0, `NFC_ADR_STATUS, 32'h0);
    chk({31'h0, rdat[`NFC_ST_REFUSED]}, 32'h1);
    wait_done;
    wb(1'b0, `NFC_ADR_RDLO, 32'h0);
    chk(rdat, exp_f[1]);
    wb(1'b1, `NFC_ADR_CTRL, {29'h0, `NFC_OP_SET_FEAT});
    repeat (6) @(posedge clk_sys);
    wb(1'b1, `NFC_ADR_CTRL, {29'h0, `NFC_OP_RESET});
    // second reset lands while the target is busy with the first
    repeat (8) @(posedge clk_sys);
    wb(1'b1, `NFC_ADR_CTRL, {29'h0, `NFC_OP_RESET});
    wait_done;
    op(`NFC_OP_STATUS, 8'h00, 32'h0);
    wb(1'b0, `NFC_ADR_RDLO, 32'h0);
    chk({24'h0, rdat[7:0]}, 32'hE0);
    conclude;
  end
endmodule
